/* File: src/ubdo_top.sv */
module ubdo_top
    import ubdo_pkg::*;
(
    input wire logic sys_clk_i, // system clock, 100 MHz
    input wire logic srst_i, // synchronous reset, active high
    input wire logic cpu_we_i, // core write strobe
    input wire logic [9:0] cpu_addr_i, // core data-memory address
    input wire logic [7:0] cpu_wdata_i, // core write data
    output logic [7:0] cpu_rdata_o, // core read data, one cycle later
    output logic cpu_hit_o, // address falls in shared RAM
    input wire logic [7:0] ep_in_en_i, // per-endpoint input enable
    input wire logic tok_valid_i, // engine token request pulse
    input wire logic [4:0] tok_bd_i, // descriptor used by token
    input wire logic [3:0] tok_pid_i, // token identifier
    input wire logic tok_data1_i, // received packet is DATA1
    input wire logic tok_err_i, // packet arrived with error
    input wire logic [9:0] tok_count_i, // bytes moved by transaction
    output logic tok_ready_o, // engine sequencer idle
    output logic done_o, // one-cycle answer pulse
    output ubdo_hs_e hs_o, // handshake for the answer
    output logic [7:0] ep_stall_set_o, // endpoint stall flag set pulse
    output logic stall_irq_o, // stall interrupt pulse
    output logic trn_done_o, // transfer-complete flag set pulse
    output logic buf_wr_en_o, // data may be written to RAM
    output logic [9:0] bd_count_o // descriptor count as read
);
    // ----------------------------------------
    // ram ports
    // ----------------------------------------
    ubdo_port_if cpu_p ();
    ubdo_port_if eng_p ();

    ubdo_dpram u_ram (
        .sys_clk_i(sys_clk_i),
        .cpu_p(cpu_p.ram),
        .eng_p(eng_p.ram)
    );

    wire logic cpu_in_ram;
    wire logic [9:0] cpu_ofs;
    assign cpu_in_ram = cpu_addr_i >= RAM_BASE && cpu_addr_i <= RAM_LAST;
    assign cpu_ofs = cpu_addr_i - RAM_BASE;
    assign cpu_p.we = cpu_we_i && cpu_in_ram;
    assign cpu_p.addr = cpu_ofs[7:0];
    assign cpu_p.wdata = cpu_wdata_i;

    logic hit_reg;
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            hit_reg <= 1'b0;
        end else begin
            hit_reg <= cpu_in_ram;
        end
    end
    assign cpu_rdata_o = hit_reg ? cpu_p.rdata : 8'h00;
    assign cpu_hit_o = hit_reg;

    // ----------------------------------------
    // engine sequencer
    // ----------------------------------------
    ubdo_state_e st_reg, st_next;
    logic [4:0] bd_reg;
    logic [3:0] pid_reg;
    logic data1_reg, err_reg;
    logic [9:0] cnt_in_reg;
    logic [7:0] stat_reg;
    logic [7:0] cnt_lo_reg;
    ubdo_hs_e hs_reg;
    logic done_reg, stall_reg, trn_reg, bufwr_reg;
    logic [1:0] act_reg; // 0 none, 1 complete, 2 stall release

    wire logic [2:0] ep_num;
    wire logic bd_live;
    wire logic own;
    wire logic is_setup;
    wire logic tog_ok;
    wire logic stalled;
    // plain mapping without ping-pong: even bd out, odd bd in
    assign ep_num = bd_reg[3:1];
    assign bd_live = ep_in_en_i[ep_num];
    assign own = stat_reg[ST_OWN];
    assign is_setup = pid_reg == PID_SETUP;
    assign stalled = stat_reg[ST_BUFFER_STALL_ENABLE];
    assign tog_ok = !stat_reg[ST_TOGGLE_CHECK_ENABLE]
        || (data1_reg == stat_reg[ST_DTS]);

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            UBDO_IDLE: begin
                if (tok_valid_i) begin
                    st_next = UBDO_RD_ST;
                end
            end
            UBDO_RD_ST: st_next = UBDO_RD_CNT;
            UBDO_RD_CNT: st_next = UBDO_DECIDE;
            UBDO_DECIDE: begin
                st_next = UBDO_IDLE;
                if (bd_live && own && !err_reg
                    && (stalled ? is_setup : tog_ok)) begin
                    st_next = UBDO_WR_CNT;
                end
            end
            UBDO_WR_CNT: st_next = UBDO_WR_ST;
            UBDO_WR_ST: st_next = UBDO_IDLE;
            default: st_next = UBDO_IDLE;
        endcase
    end
    assign tok_ready_o = st_reg == UBDO_IDLE;

    // ----------------------------------------
    // engine ram access
    // ----------------------------------------
    wire logic [7:0] wb_stat;
    wire logic wr_cnt, wr_st;
    assign wr_cnt = st_reg == UBDO_WR_CNT && act_reg == 2'h1;
    assign wr_st = st_reg == UBDO_WR_ST;
    // write-back on completion: ownership cleared, token id, high count bits; stall release clears ownership and stall bit only
    assign wb_stat = act_reg == 2'h1
        ? {1'b0, stat_reg[ST_DTS], pid_reg, cnt_in_reg[9:8]}
        : {1'b0, stat_reg[6:3], 1'b0, stat_reg[1:0]};
    assign eng_p.we = wr_cnt || wr_st;
    assign eng_p.wdata = wr_cnt ? cnt_in_reg[7:0] : wb_stat;
    assign eng_p.addr = (st_reg == UBDO_IDLE || st_reg == UBDO_RD_ST
        || wr_cnt || st_reg == UBDO_WR_CNT)
        ? ubdo_bd_addr(tok_valid_i && st_reg == UBDO_IDLE ? tok_bd_i : bd_reg,
                       (st_reg == UBDO_RD_ST || st_reg == UBDO_WR_CNT)
                       ? BD_CNT_OFS : BD_STAT_OFS)
        : ubdo_bd_addr(bd_reg, BD_STAT_OFS);

    // ----------------------------------------
    // state and captured token
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            st_reg <= UBDO_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            bd_reg <= 5'h00;
            pid_reg <= 4'h0;
            data1_reg <= 1'b0;
            err_reg <= 1'b0;
            cnt_in_reg <= 10'h000;
        end else if (tok_valid_i && st_reg == UBDO_IDLE) begin
            bd_reg <= tok_bd_i;
            pid_reg <= tok_pid_i;
            data1_reg <= tok_data1_i;
            err_reg <= tok_err_i;
            cnt_in_reg <= tok_count_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            stat_reg <= 8'h00;
            cnt_lo_reg <= 8'h00;
        end else begin
            if (st_reg == UBDO_RD_ST) begin
                stat_reg <= eng_p.rdata;
            end
            if (st_reg == UBDO_RD_CNT) begin
                cnt_lo_reg <= eng_p.rdata;
            end
        end
    end
    assign bd_count_o = {stat_reg[1:0], cnt_lo_reg};

    // ----------------------------------------
    // decision and answers
    // ----------------------------------------
    wire logic decide;
    assign decide = st_reg == UBDO_DECIDE;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            act_reg <= 2'h0;
            hs_reg <= UBDO_HS_ACK;
            done_reg <= 1'b0;
            stall_reg <= 1'b0;
            trn_reg <= 1'b0;
            bufwr_reg <= 1'b0;
        end else begin
            done_reg <= decide;
            stall_reg <= 1'b0;
            trn_reg <= 1'b0;
            bufwr_reg <= 1'b0;
            if (decide) begin
                act_reg <= 2'h0;
                if (!bd_live || !own || err_reg) begin
                    hs_reg <= UBDO_HS_NAK;
                end else if (stalled && !is_setup) begin
                    hs_reg <= UBDO_HS_STALL;
                    stall_reg <= 1'b1;
                end else if (stalled) begin
                    hs_reg <= UBDO_HS_ACK;
                    act_reg <= 2'h2;
                end else if (!tog_ok) begin
                    hs_reg <= UBDO_HS_ACK;
                end else begin
                    hs_reg <= UBDO_HS_ACK;
                    act_reg <= 2'h1;
                    trn_reg <= 1'b1;
                    bufwr_reg <= 1'b1;
                end
            end
        end
    end

    assign done_o = done_reg;
    assign hs_o = hs_reg;
    assign stall_irq_o = stall_reg;
    assign ep_stall_set_o = stall_reg ? 8'h01 << ep_num : 8'h00;
    assign trn_done_o = trn_reg;
    assign buf_wr_en_o = bufwr_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence decide_mismatch_s;
        decide && bd_live && own && !err_reg && !stalled && !tog_ok;
    endsequence
    sequence decide_good_s;
        decide && bd_live && own && !err_reg && !stalled && tog_ok;
    endsequence
    sequence decide_setup_s;
        decide && bd_live && own && !err_reg && stalled && is_setup;
    endsequence

    mismatch_no_wb_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        decide_mismatch_s |=> !trn_done_o && hs_o == UBDO_HS_ACK
            && !eng_p.we ##1 !eng_p.we)
        else $error("toggle mismatch touched descriptor");
    setup_release_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        decide_setup_s |=> hs_o == UBDO_HS_ACK && !trn_done_o
            && !eng_p.we ##1 eng_p.we && !eng_p.wdata[ST_OWN]
            && !eng_p.wdata[ST_BUFFER_STALL_ENABLE]
            && eng_p.addr == ubdo_bd_addr(bd_reg, BD_STAT_OFS))
        else $error("setup did not release stalled descriptor");
    owner_nak_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        decide && bd_live && !own |=> hs_o == UBDO_HS_NAK && !trn_done_o
            ##1 !eng_p.we)
        else $error("core-owned descriptor used by engine");
    good_release_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        decide_good_s |=> ##1 eng_p.we && !eng_p.wdata[ST_OWN])
        else $error("ownership not returned");
    good_ack_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        decide_good_s |=> trn_done_o && hs_o == UBDO_HS_ACK)
        else $error("good packet not completed");
    err_nak_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        decide && err_reg |=> hs_o == UBDO_HS_NAK && !trn_done_o)
        else $error("errored packet not refused");
    stall_answer_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        decide && bd_live && own && !err_reg && stalled && !is_setup
        |=> hs_o == UBDO_HS_STALL && stall_irq_o && !eng_p.we
            ##1 !eng_p.we)
        else $error("buffer stall not answered");
    count_carry_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        wr_st && act_reg == 2'h1
        |-> eng_p.wdata[1:0] == cnt_in_reg[9:8]
            && eng_p.wdata[5:2] == pid_reg)
        else $error("count high bits or token id wrong");
    count_low_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        wr_cnt |-> eng_p.wdata == cnt_in_reg[7:0]
            && eng_p.addr == ubdo_bd_addr(bd_reg, BD_CNT_OFS))
        else $error("count byte write wrong");
    dead_bd_a: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        decide && !bd_live |=> hs_o == UBDO_HS_NAK ##1 !eng_p.we)
        else $error("disabled endpoint descriptor used");
endmodule : ubdo_top

/* File: src/ubdo_pkg.sv */
package ubdo_pkg;
    // ----------------------------------------
    // memory map
    // ----------------------------------------
    localparam logic [9:0] RAM_BASE = 10'h200;
    localparam logic [9:0] RAM_LAST = 10'h2FF;
    localparam logic [9:0] BDT_LAST = 10'h27F;
    localparam int RAM_BYTES = 256;
    localparam int NUM_BD = 32;
    localparam int BDT_MIN_BYTES = 8;
    localparam int BDT_MAX_BYTES = 128;
    // byte order inside a descriptor
    localparam logic [1:0] BD_STAT_OFS = 2'h0;
    localparam logic [1:0] BD_CNT_OFS = 2'h1;
    localparam logic [1:0] BD_ADRL_OFS = 2'h2;
    localparam logic [1:0] BD_ADRH_OFS = 2'h3;
    // ----------------------------------------
    // status byte fields
    // ----------------------------------------
    localparam int ST_OWN = 7;
    localparam int ST_DTS = 6;
    localparam int ST_TOGGLE_CHECK_ENABLE = 3;
    localparam int ST_BUFFER_STALL_ENABLE = 2;
    localparam int ST_PID_LO = 2;
    localparam int EP_INEN = 1;
    localparam logic [3:0] PID_SETUP = 4'hD;
    localparam logic [3:0] PID_OUT = 4'h1;
    localparam logic [3:0] PID_IN = 4'h9;
    // ----------------------------------------
    // handshake codes
    // ----------------------------------------
    typedef enum logic [1:0] {
        UBDO_HS_ACK = 2'h0,
        UBDO_HS_NAK = 2'h1,
        UBDO_HS_STALL = 2'h2
    } ubdo_hs_e;
    // engine sequencer, gray coded from IDLE to WR_ST; WR_ST back to IDLE flips three bits
    typedef enum logic [2:0] {
        UBDO_IDLE = 3'h0,
        UBDO_RD_ST = 3'h1,
        UBDO_RD_CNT = 3'h3,
        UBDO_DECIDE = 3'h2,
        UBDO_WR_CNT = 3'h6,
        UBDO_WR_ST = 3'h7
    } ubdo_state_e;

    function automatic logic [7:0] ubdo_bd_addr(input logic [4:0] bd,
                                                 input logic [1:0] ofs);
        ubdo_bd_addr = {1'b0, bd, ofs};
    endfunction : ubdo_bd_addr
endpackage : ubdo_pkg

/* File: src/ubdo_port_if.sv */
interface ubdo_port_if;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport owner (output we, output addr, output wdata, input rdata);
    modport ram (input we, input addr, input wdata, output rdata);
endinterface : ubdo_port_if

/* File: src/ubdo_dpram.sv */
module ubdo_dpram (
    input wire logic sys_clk_i, // system clock
    ubdo_port_if.ram cpu_p, // core port
    ubdo_port_if.ram eng_p // engine port
);
    logic [7:0] mem [0:255];
    logic [7:0] cpu_rd_reg;
    logic [7:0] eng_rd_reg;

    // no reset: contents stay indeterminate
    // no lockout on engine-owned bytes; a clash keeps the engine write
    always_ff @(posedge sys_clk_i) begin
        if (cpu_p.we && !(eng_p.we && eng_p.addr == cpu_p.addr)) begin
            mem[cpu_p.addr] <= cpu_p.wdata;
        end
        if (eng_p.we) begin
            mem[eng_p.addr] <= eng_p.wdata;
        end
        cpu_rd_reg <= mem[cpu_p.addr];
        eng_rd_reg <= mem[eng_p.addr];
    end

    assign cpu_p.rdata = cpu_rd_reg;
    assign eng_p.rdata = eng_rd_reg;
endmodule : ubdo_dpram

/* File: test/ubdo_host_model.sv */
module ubdo_host_model
    import ubdo_pkg::*;
(
    input wire logic sys_clk_i, // system clock
    input wire logic tok_ready_i, // engine idle
    input wire logic done_i, // answer pulse
    output logic tok_valid_o, // token request
    output logic [4:0] tok_bd_o, // descriptor number
    output logic [3:0] tok_pid_o, // token identifier
    output logic tok_data1_o, // packet is DATA1
    output logic tok_err_o, // packet errored
    output logic [9:0] tok_count_o // bytes moved
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        tok_valid_o = 1'b0;
        {tok_bd_o, tok_pid_o, tok_data1_o, tok_err_o, tok_count_o} = '0;
    end

    task automatic send(input logic [4:0] bd, input logic [3:0] pid,
                        input logic d1, input logic er,
                        input logic [9:0] cnt, output logic ok);
        int n;
        n = 0;
        @(negedge sys_clk_i);
        while (tok_ready_i !== 1'b1 && n < 50) begin
            @(negedge sys_clk_i);
            n++;
        end
        {tok_bd_o, tok_pid_o, tok_data1_o, tok_err_o} = {bd, pid, d1, er};
        tok_count_o = cnt;
        tok_valid_o = 1'b1;
        // ready only moves on a rising edge, so this edge takes the token
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        tok_valid_o = 1'b0;
        // stale qualifiers are inverted so a late capture shows up
        {tok_bd_o, tok_pid_o, tok_data1_o, tok_err_o} = ~{bd, pid, d1, er};
        tok_count_o = ~cnt;
        n = 0;
        while (done_i !== 1'b1 && n < 50) begin
            @(negedge sys_clk_i);
            n++;
        end
        ok = (done_i === 1'b1);
    endtask : send
endmodule : ubdo_host_model

/* File: test/test_ubdo_top.sv */
module test_ubdo_top
    import ubdo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i, srst_i, cpu_we_i, tok_valid_i, tok_data1_i, tok_err_i;
    logic [9:0] cpu_addr_i, tok_count_i, bd_count_o;
    logic [7:0] cpu_wdata_i, cpu_rdata_o, ep_in_en_i, ep_stall_set_o;
    logic [4:0] tok_bd_i;
    logic [3:0] tok_pid_i;
    logic cpu_hit_o, tok_ready_o, done_o, stall_irq_o, trn_done_o;
    logic buf_wr_en_o, ok, trn, bwr, irq;
    ubdo_hs_e hs_o, hs;
    logic [7:0] sset;
    logic [9:0] bcnt;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;

    ubdo_top i_ubdo_top (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .cpu_we_i(cpu_we_i), .cpu_addr_i(cpu_addr_i),
        .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o),
        .cpu_hit_o(cpu_hit_o), .ep_in_en_i(ep_in_en_i),
        .tok_valid_i(tok_valid_i), .tok_bd_i(tok_bd_i),
        .tok_pid_i(tok_pid_i), .tok_data1_i(tok_data1_i),
        .tok_err_i(tok_err_i), .tok_count_i(tok_count_i),
        .tok_ready_o(tok_ready_o), .done_o(done_o), .hs_o(hs_o),
        .ep_stall_set_o(ep_stall_set_o), .stall_irq_o(stall_irq_o),
        .trn_done_o(trn_done_o), .buf_wr_en_o(buf_wr_en_o),
        .bd_count_o(bd_count_o));
    ubdo_host_model i_ubdo_host_model (.sys_clk_i(sys_clk_i),
        .tok_ready_i(tok_ready_o), .done_i(done_o),
        .tok_valid_o(tok_valid_i), .tok_bd_o(tok_bd_i),
        .tok_pid_o(tok_pid_i), .tok_data1_o(tok_data1_i),
        .tok_err_o(tok_err_i), .tok_count_o(tok_count_i));

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [9:0] e,
                       input logic [9:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(negedge sys_clk_i);
        {cpu_addr_i, cpu_wdata_i, cpu_we_i} = {a, v, 1'b1};
        @(negedge sys_clk_i);
        cpu_we_i = 1'b0;
    endtask : wr

    task automatic rd(input logic [9:0] a, input logic [7:0] e,
                      input logic eh);
        @(negedge sys_clk_i);
        cpu_addr_i = a;
        @(negedge sys_clk_i);
        chk("rdata", {2'h0, e}, {2'h0, cpu_rdata_o});
        chk("hit", {9'h0, eh}, {9'h0, cpu_hit_o});
    endtask : rd

    // count, address, then status last so the engine sees a whole set
    task automatic arm(input logic [7:0] st, input logic [7:0] cnt);
        wr(10'h209, cnt);
        wr(10'h20A, 8'h80);
        wr(10'h20B, 8'h02);
        wr(10'h208, st);
    endtask : arm

    task automatic tk(input logic [3:0] pid, input logic d1, input logic er);
        int n;
        i_ubdo_host_model.send(5'h02, pid, d1, er, bcnt, ok);
        chk("done", 10'h1, {9'h0, ok});
        hs = hs_o;
        {sset, irq, trn, bwr} = {ep_stall_set_o, stall_irq_o, trn_done_o,
                                 buf_wr_en_o};
        n = 0;
        while (tok_ready_o !== 1'b1 && n < 20) begin
            @(negedge sys_clk_i);
            n++;
        end
    endtask : tk

    task automatic res(input ubdo_hs_e eh, input logic et);
        chk("hs", {8'h0, eh}, {8'h0, hs});
        chk("trn_done", {9'h0, et}, {9'h0, trn});
        chk("buf_wr", {9'h0, et}, {9'h0, bwr});
    endtask : res

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {srst_i, cpu_we_i, cpu_addr_i, cpu_wdata_i} = {1'b1, 1'b0, 18'h0};
        ep_in_en_i = 8'h00;
        bcnt = 10'h000;
        repeat (5) @(negedge sys_clk_i);
        srst_i = 1'b0;
        chk("ready", 10'h1, {9'h0, tok_ready_o});
        chk("bd_count", 10'h0, bd_count_o);
        wr(10'h200, 8'h5A);
        wr(10'h2FF, 8'hA5);
        rd(10'h200, 8'h5A, 1'b1);
        rd(10'h2FF, 8'hA5, 1'b1);
        rd(10'h1FF, 8'h00, 1'b0);
        rd(10'h300, 8'h00, 1'b0);
        arm(8'hC9, 8'h40);
        ep_in_en_i = 8'h02;
        rd(10'h208, 8'hC9, 1'b1);
        bcnt = 10'h12A;
        tk(PID_OUT, 1'b1, 1'b0);
        res(UBDO_HS_ACK, 1'b1);
        chk("bd_count", 10'h140, bd_count_o);
        rd(10'h208, 8'h45, 1'b1);
        rd(10'h209, 8'h2A, 1'b1);
        arm(8'h88, 8'h10);
        tk(PID_OUT, 1'b1, 1'b0);
        res(UBDO_HS_ACK, 1'b0);
        rd(10'h208, 8'h88, 1'b1);
        rd(10'h209, 8'h10, 1'b1);
        arm(8'hC0, 8'h08);
        bcnt = 10'h3FF;
        tk(PID_OUT, 1'b1, 1'b0);
        res(UBDO_HS_ACK, 1'b1);
        rd(10'h208, 8'h47, 1'b1);
        rd(10'h209, 8'hFF, 1'b1);
        arm(8'h80, 8'h08);
        tk(PID_OUT, 1'b0, 1'b1);
        res(UBDO_HS_NAK, 1'b0);
        rd(10'h208, 8'h80, 1'b1);
        arm(8'h84, 8'h08);
        tk(PID_IN, 1'b0, 1'b0);
        res(UBDO_HS_STALL, 1'b0);
        chk("stall_set", 10'h002, {2'h0, sset});
        chk("stall_irq", 10'h1, {9'h0, irq});
        rd(10'h208, 8'h84, 1'b1);
        tk(PID_SETUP, 1'b0, 1'b0);
        chk("hs", {8'h0, UBDO_HS_ACK}, {8'h0, hs});
        chk("trn_done", 10'h0, {9'h0, trn});
        rd(10'h208, 8'h00, 1'b1);
        rd(10'h209, 8'h08, 1'b1);
        tk(PID_OUT, 1'b0, 1'b0);
        res(UBDO_HS_NAK, 1'b0);
        arm(8'h80, 8'h08);
        ep_in_en_i = 8'h00;
        tk(PID_OUT, 1'b0, 1'b0);
        res(UBDO_HS_NAK, 1'b0);
        rd(10'h208, 8'h80, 1'b1);
        stop_test();
    end
endmodule : test_ubdo_top
